// *** rtl/bus_master_front.sv ***
// Arbiter, byte-lane and exception front end of an expansion-bus master.
// Assumes all pin inputs are synchronous to clk_i; a board resolves the
// open-collector lines from the _oe_o outputs.
//
// What this block does
// - A low local bus request drives the shared preempt line low, open-collector.
// - A low local burst request becomes the burst request shown on the bus.
// - Fairness waits for an idle preempt line between tenures only while enabled.
// - Card select low marks the adapter selected; high resets arbitration state.
// - The adapter competes at the level given by the three programmed level inputs.
// - Level lines 0 to 2 are driven open-collector; line 3 is only sensed.
// - The arbitrate/grant input separates arbitration periods from grant periods.
// - Master enable goes low while the local master owns the bus.
// - The burst output goes low to mark an owned tenure as a burst.
// - The command strobe tells when a transfer is still carrying data.
// - Error reports are taken only while reporting is enabled and master active.
// - Once an error is reported the open-collector exception output goes low.
// - Four active-low lane enables mark the byte lanes placed on the bus.
// - The lane unit drives the bus one cycle behind master enable: from the cycle after it goes low until the cycle after it goes high.
// - High byte enable and address bits 0 and 1 serve 16 bit transfers.
// - Lane outputs follow local address bits 0 and 1 and the size inputs.
// - A low wide stream request means the slave wants 64 bit streaming.
// - Under a wide stream request all lane enables are driven high.
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module bus_master_front
  import bus_master_pkg::*;
(
  // System.
  input wire logic clk_i,
  input wire logic rst_i,
  // Local requests and configuration.
  input wire logic local_bus_req_n_i,
  input wire logic local_burst_req_n_i,
  input wire logic fairness_en_i,
  input wire logic card_select_n_i,
  input wire logic prog_level0_i,
  input wire logic prog_level1_i,
  input wire logic prog_level2_i,
  // Shared arbitration lines.
  input wire logic arbitrate_grant_i,
  input wire logic arb_level_line3_i,
  input wire logic arb_level_line2_i,
  input wire logic arb_level_line1_i,
  input wire logic arb_level_line0_i,
  output logic arb_level_line2_o,
  output logic arb_level_line1_o,
  output logic arb_level_line0_o,
  output logic arb_level_line2_oe_o,
  output logic arb_level_line1_oe_o,
  output logic arb_level_line0_oe_o,
  input wire logic preempt_n_i,
  output logic preempt_n_o,
  output logic preempt_oe_o,
  input wire logic cmd_n_i,
  output logic master_own_n_o,
  output logic burst_n_o,
  // Byte lanes and exceptions.
  input wire logic local_addr_bit0_i,
  input wire logic local_addr_bit1_i,
  input wire logic xfer_size_bit0_i,
  input wire logic xfer_size_bit1_i,
  input wire logic wide_stream_req_n_i,
  input wire logic channel_error_n_i,
  input wire logic error_report_en_n_i,
  output logic exception_n_o,
  output logic exception_oe_o,
  output logic high_byte_en_n_o,
  output logic bus_addr_bit0_o,
  output logic bus_addr_bit1_o,
  output logic lane0_en_n_o,
  output logic lane1_en_n_o,
  output logic lane2_en_n_o,
  output logic lane3_en_n_o,
  // Register bus.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  ////////////////////////////////////////////////////////////////////////////

  arb_state_t state_reg, state_next;
  logic [3:0] div_reg, div_next;
  logic tick_reg, tick_next;
  logic won_reg, won_next;
  logic fair_hold_reg, fair_hold_next;
  logic [2:0] arb_oe_reg, arb_oe_next;
  logic preempt_oe_reg, preempt_oe_next;
  logic own_n_reg, own_n_next;
  logic burst_n_reg, burst_n_next;
  logic [3:0] lanes_n_reg, lanes_n_next;
  logic hbe_n_reg, hbe_n_next;
  logic [1:0] addr_reg, addr_next;
  logic exc_reg, exc_next;
  logic zero_reg;
  logic arb_en_reg, arb_en_next;
  logic fair_force_reg, fair_force_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [2:0] level;
  logic [3:0] sensed;
  logic [1:0] laddr;
  logic [1:0] lsize;
  logic [3:0] mask;
  logic fair_on;
  logic done;

  assign level = {prog_level2_i, prog_level1_i, prog_level0_i};
  assign sensed = {arb_level_line3_i, arb_level_line2_i, arb_level_line1_i, arb_level_line0_i};
  assign laddr = {local_addr_bit1_i, local_addr_bit0_i};
  assign lsize = {xfer_size_bit1_i, xfer_size_bit0_i};
  assign mask = lane_mask(laddr, lsize);
  assign fair_on = fairness_en_i | fair_force_reg;
  // Apart from a card deselect, a tenure may only end between transfers, never with data on the bus.
  assign done = cmd_n_i;

  ////////////////////////////////////////////////////////////////////////////

  // Arbiter and lane unit. The arbiter moves only on the bus-rate enable,
  // so decisions match what a 10 MHz part would have seen.
  always_comb begin
    div_next = (div_reg == TICK_LAST) ? 4'h0 : div_reg + 4'h1;
    tick_next = (div_reg == TICK_LAST);
    state_next = state_reg;
    won_next = won_reg;
    fair_hold_next = fair_hold_reg;
    if (tick_reg) begin
      unique case (state_reg)
        ST_IDLE: begin
          won_next = 1'b0;
          // The hold lasts until some tick sees nobody asking for the bus.
          if (preempt_n_i) begin
            fair_hold_next = 1'b0;
          end
          if (!card_select_n_i && arb_en_reg && !local_bus_req_n_i && !fair_hold_reg) begin
            state_next = ST_REQ;
          end
        end
        ST_REQ: begin
          if (local_bus_req_n_i) begin
            state_next = ST_IDLE;
          end else if (arbitrate_grant_i) begin
            won_next = (sensed == {ARB_LEVEL_LINE3_WIN_LEVEL, level});
          end else if (won_reg) begin
            state_next = ST_OWN;
          end
        end
        ST_OWN: begin
          if ((local_bus_req_n_i || arbitrate_grant_i) && done) begin
            state_next = ST_IDLE;
            fair_hold_next = fair_on;
          end
        end
        default: state_next = ST_IDLE;
      endcase
      if (card_select_n_i) begin
        state_next = ST_IDLE;
        won_next = 1'b0;
        fair_hold_next = 1'b0;
      end
    end
    // Pulling a line low shows a zero bit of our level; ones are left to float.
    arb_oe_next = (state_next == ST_REQ && arbitrate_grant_i) ? ~level : 3'h0;
    preempt_oe_next = (state_next == ST_REQ);
    own_n_next = (state_next != ST_OWN);
    burst_n_next = !(state_next == ST_OWN && !local_burst_req_n_i);
    if (!own_n_reg) begin
      // Wide streaming carries data on the address lines too, so no lane is marked.
      lanes_n_next = !wide_stream_req_n_i ? 4'hf : ~mask;
      hbe_n_next = !(mask[1] | mask[3]);
      addr_next = laddr;
    end else begin
      lanes_n_next = 4'hf;
      hbe_n_next = 1'b1;
      addr_next = 2'h0;
    end
    // The enable pulse clears; a report needs the enable low, so an error during the pulse is lost.
    if (error_report_en_n_i) begin
      exc_next = 1'b0;
    end else begin
      exc_next = exc_reg | (!own_n_reg && !channel_error_n_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      div_reg <= 4'h0;
      tick_reg <= 1'b0;
      won_reg <= 1'b0;
      fair_hold_reg <= 1'b0;
      arb_oe_reg <= 3'h0;
      preempt_oe_reg <= 1'b0;
      own_n_reg <= 1'b1;
      burst_n_reg <= 1'b1;
      lanes_n_reg <= 4'hf;
      hbe_n_reg <= 1'b1;
      addr_reg <= 2'h0;
      exc_reg <= 1'b0;
      zero_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      div_reg <= div_next;
      tick_reg <= tick_next;
      won_reg <= won_next;
      fair_hold_reg <= fair_hold_next;
      arb_oe_reg <= arb_oe_next;
      preempt_oe_reg <= preempt_oe_next;
      own_n_reg <= own_n_next;
      burst_n_reg <= burst_n_next;
      lanes_n_reg <= lanes_n_next;
      hbe_n_reg <= hbe_n_next;
      addr_reg <= addr_next;
      exc_reg <= exc_next;
      zero_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Register bus slave. Every access is answered one cycle after the strobe;
  // unmapped addresses read zero and ignore writes.
  always_comb begin
    arb_en_next = arb_en_reg;
    fair_force_next = fair_force_reg;
    ack_next = 1'b0;
    rdat_next = rdat_reg;
    if (wb_cyc_i && wb_stb_i && !ack_reg) begin
      ack_next = 1'b1;
      rdat_next = 32'h0;
      if (wb_we_i && wb_sel_i[0] && wb_adr_i == CTRL_OFS) begin
        arb_en_next = wb_dat_i[CTRL_ARB_EN_BIT];
        fair_force_next = wb_dat_i[CTRL_FAIR_FORCE_BIT];
      end
      if (!wb_we_i && wb_adr_i == CTRL_OFS) begin
        rdat_next[CTRL_ARB_EN_BIT] = arb_en_reg;
        rdat_next[CTRL_FAIR_FORCE_BIT] = fair_force_reg;
      end
      if (!wb_we_i && wb_adr_i == STAT_OFS) begin
        rdat_next[STAT_STATE_LSB +: 2] = state_reg;
        rdat_next[STAT_OWN_BIT] = !own_n_reg;
        rdat_next[STAT_EXC_BIT] = exc_reg;
        rdat_next[STAT_LANES_LSB +: 4] = ~lanes_n_reg;
        rdat_next[STAT_FAIR_BIT] = fair_hold_reg;
        rdat_next[STAT_WON_BIT] = won_reg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arb_en_reg <= CTRL_ARB_EN_RST;
      fair_force_reg <= CTRL_FAIR_FORCE_RST;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      arb_en_reg <= arb_en_next;
      fair_force_reg <= fair_force_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign arb_level_line2_o = zero_reg;
  assign arb_level_line1_o = zero_reg;
  assign arb_level_line0_o = zero_reg;
  assign arb_level_line2_oe_o = arb_oe_reg[2];
  assign arb_level_line1_oe_o = arb_oe_reg[1];
  assign arb_level_line0_oe_o = arb_oe_reg[0];
  assign preempt_n_o = zero_reg;
  assign preempt_oe_o = preempt_oe_reg;
  assign master_own_n_o = own_n_reg;
  assign burst_n_o = burst_n_reg;
  assign exception_n_o = zero_reg;
  assign exception_oe_o = exc_reg;
  assign high_byte_en_n_o = hbe_n_reg;
  assign bus_addr_bit0_o = addr_reg[0];
  assign bus_addr_bit1_o = addr_reg[1];
  assign lane0_en_n_o = lanes_n_reg[0];
  assign lane1_en_n_o = lanes_n_reg[1];
  assign lane2_en_n_o = lanes_n_reg[2];
  assign lane3_en_n_o = lanes_n_reg[3];
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_preempt_on_req: assert property (
    tick_reg && state_reg == ST_IDLE && !local_bus_req_n_i && !card_select_n_i
    && arb_en_reg && !fair_hold_reg |=> preempt_oe_o && master_own_n_o)
    else $error("Preempt not raised for a local bus request.");

  a_burst_in_own: assert property (
    !burst_n_o |-> !master_own_n_o && !$past(local_burst_req_n_i))
    else $error("Burst shown outside an owned tenure.");

  a_fair_hold_idle: assert property (
    fair_hold_reg && tick_reg && preempt_n_i && !card_select_n_i |=> !fair_hold_reg)
    else $error("Fairness hold kept while the preempt line is idle.");

  a_card_reset: assert property (
    tick_reg && card_select_n_i |=> state_reg == ST_IDLE ##1 master_own_n_o && !preempt_oe_o)
    else $error("Card deselect did not reset the arbiter.");

  a_level_drive: assert property (
    arb_level_line0_oe_o || arb_level_line1_oe_o || arb_level_line2_oe_o
    |-> state_reg == ST_REQ && $past(arbitrate_grant_i))
    else $error("Level lines driven outside arbitration.");

  a_grant_needs_win: assert property (
    state_reg == ST_REQ && !won_reg |=> state_reg != ST_OWN)
    else $error("Ownership taken without winning arbitration.");

  a_lane_run: assert property (
    !own_n_reg && wide_stream_req_n_i |=> {lane3_en_n_o, lane2_en_n_o, lane1_en_n_o,
    lane0_en_n_o} == ~lane_mask($past(laddr), $past(lsize)))
    else $error("Lane enables do not match address and size.");

  a_wide_all_high: assert property (
    !own_n_reg && !wide_stream_req_n_i |=> {lane3_en_n_o, lane2_en_n_o, lane1_en_n_o,
    lane0_en_n_o} == 4'hf)
    else $error("Lane enables not all high under wide streaming.");

  a_exc_latch: assert property (
    !own_n_reg && !error_report_en_n_i && !channel_error_n_i
    ##1 !error_report_en_n_i [*2] |-> exception_oe_o)
    else $error("Reported error did not raise the exception output.");

  a_exc_clear: assert property (
    error_report_en_n_i |=> !exception_oe_o)
    else $error("Exception not cleared by the report enable pulse.");

  a_release: assert property (
    tick_reg && state_reg == ST_OWN && local_bus_req_n_i && cmd_n_i
    |=> ##1 !preempt_oe_o && master_own_n_o)
    else $error("Ownership kept after the request was withdrawn.");

  a_wb_ack_once: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Register bus answer not a single cycle after the strobe.");

endmodule

`default_nettype wire

// *** rtl/bus_master_pkg.sv ***
// Constants, types and helpers shared by the bus master front end.
// Assumes a 100 MHz system clock from which the 10 MHz bus rate is derived.
package bus_master_pkg;

  // Clock rates and the divider that makes the bus-rate enable.
  localparam int SYS_CLK_MHZ = 100;
  localparam int BUS_CLK_MHZ = 10;
  localparam int TICK_DIV = SYS_CLK_MHZ / BUS_CLK_MHZ;
  localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);

  // Register map, byte addresses on the register bus.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;

  // Control register fields and reset values.
  localparam int CTRL_ARB_EN_BIT = 0;
  localparam logic CTRL_ARB_EN_RST = 1'b1;
  localparam int CTRL_FAIR_FORCE_BIT = 1;
  localparam logic CTRL_FAIR_FORCE_RST = 1'b0;

  // Status register fields.
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_OWN_BIT = 2;
  localparam int STAT_EXC_BIT = 3;
  localparam int STAT_LANES_LSB = 4;
  localparam int STAT_FAIR_BIT = 8;
  localparam int STAT_WON_BIT = 9;

  // Level seen on the sense-only level line 3 when this adapter may win.
  localparam logic ARB_LEVEL_LINE3_WIN_LEVEL = 1'b1;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REQ,
    ST_OWN
  } arb_state_t;

  // Contiguous lanes from the start lane, cut off at the word boundary.
  function automatic logic [3:0] lane_mask(input logic [1:0] addr, input logic [1:0] size);
    logic [7:0] run;
    run = {4'h0, 4'(4'hf >> (2'd3 - size))} << addr;
    return run[3:0];
  endfunction

endpackage

// *** tb/bus_side_model.sv ***
// Partner model: system arbiter plus a rival master that outranks this one.
// Assumes one clock; all open-collector lines are pulled up.
`timescale 1ns/1ps
`default_nettype none
module bus_side_model (
  // System.
  input wire logic clk_i,
  input wire logic rst_i,
  // Front end drive and bench commands.
  input wire logic [2:0] arb_oe_i,
  input wire logic preempt_oe_i,
  input wire logic master_own_n_i,
  input wire logic rival_on_i,
  input wire logic rival_pre_i,
  // Resolved lines.
  output logic [3:0] arb_lines_o,
  output logic preempt_n_o,
  output logic arbitrate_grant_o
);
  logic [5:0] wait_reg, wait_next;
  logic grant_reg, grant_next;
  ////////////////////////////////////////
  // A line reads low while any party pulls it; the rival also holds line 3 low.
  assign arb_lines_o = ~{rival_on_i, arb_oe_i | {3{rival_on_i}}};
  assign preempt_n_o = ~(preempt_oe_i | rival_pre_i);
  assign arbitrate_grant_o = ~grant_reg;
  // Grant after 40 cycles of arbitration, so four bus ticks see the levels settle.
  always_comb begin
    wait_next = 6'h00;
    grant_next = grant_reg;
    if (!grant_reg) begin
      wait_next = preempt_n_o ? 6'h00 : wait_reg + 6'h01;
      grant_next = (wait_reg == 6'h28);
    end else if (preempt_n_o && master_own_n_i) begin
      grant_next = 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_reg <= 6'h00;
      grant_reg <= 1'b0;
    end else begin
      wait_reg <= wait_next;
      grant_reg <= grant_next;
    end
  end
endmodule
`default_nettype wire

// *** tb/bus_master_front_tb.sv ***
// Self-checking bench for the bus master front end.
// Assumes the partner model; command, channel check and wide request come from here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module bus_master_front_tb;
  import bus_master_pkg::*;
  logic clk = 1'b0, rst = 1'b1, breq_n = 1'b1, brst_n = 1'b1, fair = 1'b0, card_n = 1'b0;
  logic ron = 1'b0, rpre = 1'b0, cmd_n = 1'b1, chk_n = 1'b1, wide_n = 1'b1, rep_n = 1'b0;
  logic cyc = 1'b0, we = 1'b0, poe, own_n, bst_n, exc, hbe_n, ack, pre_n, gnt, exn;
  logic [1:0] addr = 2'h0, size = 2'h0, ba;
  logic [2:0] lvl = 3'h0, aoe;
  logic [3:0] ln, lan_n;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  int fails = 0, n_tests = 0;
  always #5 clk = ~clk;
  bus_master_front u_bus_master_front (.clk_i(clk), .rst_i(rst),
    .local_bus_req_n_i(breq_n), .local_burst_req_n_i(brst_n), .fairness_en_i(fair),
    .card_select_n_i(card_n), .prog_level0_i(lvl[0]), .prog_level1_i(lvl[1]),
    .prog_level2_i(lvl[2]), .arbitrate_grant_i(gnt), .arb_level_line3_i(ln[3]),
    .arb_level_line2_i(ln[2]), .arb_level_line1_i(ln[1]), .arb_level_line0_i(ln[0]),
    .arb_level_line2_o(), .arb_level_line1_o(), .arb_level_line0_o(),
    .arb_level_line2_oe_o(aoe[2]), .arb_level_line1_oe_o(aoe[1]),
    .arb_level_line0_oe_o(aoe[0]), .preempt_n_i(pre_n), .preempt_n_o(), .preempt_oe_o(poe),
    .cmd_n_i(cmd_n), .master_own_n_o(own_n), .burst_n_o(bst_n),
    .local_addr_bit0_i(addr[0]), .local_addr_bit1_i(addr[1]), .xfer_size_bit0_i(size[0]),
    .xfer_size_bit1_i(size[1]), .wide_stream_req_n_i(wide_n), .channel_error_n_i(chk_n),
    .error_report_en_n_i(rep_n), .exception_n_o(exn), .exception_oe_o(exc),
    .high_byte_en_n_o(hbe_n), .bus_addr_bit0_o(ba[0]), .bus_addr_bit1_o(ba[1]),
    .lane0_en_n_o(lan_n[0]), .lane1_en_n_o(lan_n[1]), .lane2_en_n_o(lan_n[2]),
    .lane3_en_n_o(lan_n[3]), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  bus_side_model u_bus_side_model (.clk_i(clk), .rst_i(rst), .arb_oe_i(aoe),
    .preempt_oe_i(poe), .master_own_n_i(own_n), .rival_on_i(ron), .rival_pre_i(rpre),
    .arb_lines_o(ln), .preempt_n_o(pre_n), .arbitrate_grant_o(gnt));
  ////////////////////////////////////////
  // The request is held until the edge that sees ack, then released.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    repeat (20) if (ack !== 1'b1) @(posedge clk);
    `CHK(ack, 1'b1)
    q = rdat;
    cyc <= 1'b0;
    @(posedge clk);
  endtask
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic get_bus(input logic [2:0] l);
    lvl <= l;
    brst_n <= 1'b0;
    breq_n <= 1'b0;
    repeat (30) if (poe !== 1'b1) @(posedge clk);
    `CHK(poe, 1'b1)
    repeat (40) if (aoe !== ~l) @(posedge clk);
    `CHK(aoe, ~l)
    repeat (200) if (own_n !== 1'b0) @(posedge clk);
    @(posedge clk);
    `CHK(own_n, 1'b0)
    `CHK(bst_n, 1'b0)
  endtask
  // Data still moving must keep the tenure open after the request goes.
  task automatic drop_bus;
    cmd_n <= 1'b0;
    breq_n <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK(own_n, 1'b0)
    cmd_n <= 1'b1;
    repeat (30) if (own_n !== 1'b1) @(posedge clk);
    @(posedge clk);
    `CHK({own_n, bst_n, poe}, 3'h6)
    `CHK(lan_n, 4'hf)
    brst_n <= 1'b1;
  endtask
  task automatic t_lanes;
    logic [3:0] m;
    for (int i = 0; i < 16; i++) begin
      addr <= i[1:0];
      size <= i[3:2];
      repeat (2) @(posedge clk);
      for (int j = 0; j < 4; j++) m[j] = (j >= i % 4) && (j <= i % 4 + i / 4);
      `CHK(lan_n, ~m)
      `CHK({hbe_n, ba}, {~(m[1] | m[3]), i[1:0]})
    end
    wide_n <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(lan_n, 4'hf)
    // Status while owning under a wide request: owning state, no lanes, won.
    wb(1'b0, STAT_OFS, 32'h0);
    `CHK(q, (32'h2 << STAT_STATE_LSB) | (32'h1 << STAT_OWN_BIT) | (32'h1 << STAT_WON_BIT))
    wide_n <= 1'b1;
  endtask
  task automatic t_error;
    chk_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk_n <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK(exc, 1'b1)
    `CHK(exn, 1'b0)
    rep_n <= 1'b1;
    chk_n <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(exc, 1'b0)
    rep_n <= 1'b0;
    chk_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic t_idle;
    wb(1'b0, CTRL_OFS, 32'h0);
    `CHK(q, {30'h0, CTRL_FAIR_FORCE_RST, CTRL_ARB_EN_RST})
    wb(1'b1, 8'h10, 32'hffffffff);
    wb(1'b0, 8'h10, 32'h0);
    `CHK(q, 32'h0)
    card_n <= 1'b1;
    chk_n <= 1'b0;
    breq_n <= 1'b0;
    repeat (40) @(posedge clk);
    `CHK({poe, exc}, 2'h0)
    card_n <= 1'b0;
    chk_n <= 1'b1;
    breq_n <= 1'b1;
    repeat (30) @(posedge clk);
    // With arbitration switched off a request must not reach the preempt line.
    wb(1'b1, CTRL_OFS, 32'h0);
    breq_n <= 1'b0;
    repeat (30) @(posedge clk);
    `CHK(poe, 1'b0)
    breq_n <= 1'b1;
    wb(1'b1, CTRL_OFS, 32'h1);
    wb(1'b0, CTRL_OFS, 32'h0);
    `CHK(q, 32'h1)
    repeat (20) @(posedge clk);
  endtask
  // A rival holding line 3 low must never let this master win.
  task automatic t_lose;
    ron <= 1'b1;
    breq_n <= 1'b0;
    repeat (150) @(posedge clk);
    `CHK({own_n, poe}, 2'h3)
    breq_n <= 1'b1;
    ron <= 1'b0;
    repeat (30) @(posedge clk);
  endtask
  task automatic t_fair;
    fair <= 1'b1;
    get_bus(3'h3);
    rpre <= 1'b1;
    drop_bus;
    breq_n <= 1'b0;
    repeat (60) @(posedge clk);
    `CHK(poe, 1'b0)
    rpre <= 1'b0;
    repeat (30) if (poe !== 1'b1) @(posedge clk);
    `CHK(poe, 1'b1)
    breq_n <= 1'b1;
    repeat (40) @(posedge clk);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_idle;
    get_bus(3'h5);
    t_lanes;
    t_error;
    drop_bus;
    t_lose;
    t_fair;
    stop_test;
  end
  initial begin
    #200000;
    fails++;
    stop_test;
  end
endmodule
`default_nettype wire
